// ==== hdl/ursrx_top.sv ====
/*
  asynchronous serial receiver with start-bit clock recovery, majority-vote
  data recovery, parity checker, two-entry buffer and an APB register slave.
  assumes: sample_tick_i is a one-cycle pulse at 16x (8x in double speed) the
  bit rate from logic on core_clk_i; serial_in_i is asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module ursrx_top (
  input  wire logic                        core_clk_i,       // system clock
  input  wire logic                        arst_n_i,         // async reset
  input  wire logic                        psel_i,           // apb select
  input  wire logic                        penable_i,        // apb access phase
  input  wire logic                        pwrite_i,         // apb direction
  input  wire logic [ursrx_pkg::ADDR_W-1:0] paddr_i,         // apb byte address
  input  wire logic [31:0]                 pwdata_i,         // apb write data
  input  wire logic [3:0]                  pstrb_i,          // apb byte strobes
  output logic      [31:0]                 prdata_o,         // apb read data
  output logic                             pready_o,         // apb ready
  output logic                             pslverr_o,        // apb error
  input  wire logic                        serial_in_i,      // receive line
  input  wire logic                        sample_tick_i,    // oversampling tick
  input  wire logic                        global_irq_on_i,  // global irq enable
  output logic                             irq_o,            // receive-done irq
  output logic                             pin_override_o    // pin used by receiver
);
  import ursrx_pkg::*;

  // ==========================================================================
  // helpers
  // ==========================================================================
  // two-of-three vote
  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  // data bits per character from the size code
  function automatic logic [3:0] char_len(input logic [2:0] size);
    if (size == SIZE_NINE) begin
      char_len = LEN_NINE;
    end else if (size[2]) begin
      char_len = LEN_EIGHT;  // reserved codes act as eight bits
    end else begin
      char_len = LEN_BASE + {2'b00, size[1:0]};
    end
  endfunction

  // ==========================================================================
  // control registers
  // ==========================================================================
  logic       dbl_q;      // double_speed_select
  logic       irq_on_q;   // receive_done_irq_on
  logic       rx_on_q;    // receiver_on
  logic       size2_q;    // character size high bit
  logic       par_on_q;   // parity_check_on
  logic       par_odd_q;  // parity_odd_select
  logic       stop2_q;    // stop_bit_count_select, kept for software only
  logic [1:0] size_lo_q;  // character size low bits

  // ==========================================================================
  // apb decode
  // ==========================================================================
  wire logic setup_w   = psel_i & ~penable_i;
  wire logic access_w  = psel_i & penable_i;
  wire logic hit_data  = (paddr_i == OFF_DATA);
  wire logic hit_a     = (paddr_i == OFF_STAT_A);
  wire logic hit_b     = (paddr_i == OFF_CTRL_B);
  wire logic hit_c     = (paddr_i == OFF_CTRL_C);
  wire logic mapped_w  = hit_data | hit_a | hit_b | hit_c;
  wire logic wr_lane0  = access_w & pwrite_i & pstrb_i[0];
  wire logic wr_a      = wr_lane0 & hit_a;
  wire logic wr_b      = wr_lane0 & hit_b;
  wire logic wr_c      = wr_lane0 & hit_c;

  // zero-wait slave; unmapped addresses answer with an error
  assign pready_o  = 1'b1;
  assign pslverr_o = access_w & ~mapped_w;

  // ==========================================================================
  // input synchroniser and sample history
  // ==========================================================================
  logic [1:0] rx_sync_q;  // two-flop synchroniser, stage 1 read only by stage 2
  logic       prev_q;     // line level at the previous sample tick
  wire logic  rx_s     = rx_sync_q[1];
  wire logic  tick_w   = sample_tick_i & rx_on_q;

  // synchronise the asynchronous line
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_sync_q <= 2'b11;
    end else begin
      rx_sync_q <= {rx_sync_q[0], serial_in_i};
    end
  end

  // previous sample, idle high while the receiver is off
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_q <= 1'b1;
    end else if (!rx_on_q) begin
      prev_q <= 1'b1;
    end else if (tick_w) begin
      prev_q <= rx_s;
    end
  end

  // ==========================================================================
  // bit timing and voting
  // ==========================================================================
  ursrx_state_t state_q;
  logic [4:0]   cnt_q;     // sample number within the current bit
  logic [1:0]   vote_q;    // first two centre samples
  logic [3:0]   bitcnt_q;  // data bits received so far
  logic [8:0]   shift_q;   // data bits, shifted in from the top
  logic         par_bit_q; // received parity bit

  wire logic [4:0] spb_w    = dbl_q ? SPB_DOUBLE : SPB_NORMAL;
  wire logic [4:0] vfirst_w = dbl_q ? VOTE_DOUBLE : VOTE_NORMAL;
  wire logic [4:0] vlast_w  = vfirst_w + VOTE_SPAN;
  wire logic [3:0] len_w    = char_len({size2_q, size_lo_q});
  wire logic in_vote  = tick_w & (cnt_q >= vfirst_w) & (cnt_q < vlast_w);
  wire logic vote_end = tick_w & (cnt_q == vlast_w);
  wire logic bit_end  = tick_w & (cnt_q == spb_w);
  wire logic maj_w    = maj3(vote_q[1], vote_q[0], rx_s);
  wire logic idle_w   = (state_q == ST_IDLE);
  wire logic start_edge = tick_w & idle_w & prev_q & ~rx_s;
  wire logic last_data  = (bitcnt_q == len_w);  // count already holds the bit voted at sample 10 (6 in double speed)
  wire logic frame_done = vote_end & (state_q == ST_STOP);

  // sample counter: first low sample is 1, wraps each bit
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= CNT_ONE;
    end else if (!rx_on_q || (tick_w && idle_w && !start_edge)) begin
      cnt_q <= CNT_ONE;
    end else if (start_edge) begin
      cnt_q <= CNT_TWO;
    end else if (bit_end) begin
      cnt_q <= CNT_ONE;
    end else if (tick_w) begin
      cnt_q <= cnt_q + CNT_ONE;
    end
  end

  // collect the first two centre samples
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vote_q <= 2'b00;
    end else if (in_vote) begin
      vote_q <= {vote_q[0], rx_s};
    end
  end

  // frame sequence; off abandons any frame at once
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
    end else if (!rx_on_q) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_edge) begin
            state_q <= ST_START;
          end
        end
        ST_START: begin
          if (vote_end && maj_w) begin
            state_q <= ST_IDLE;
          end else if (bit_end) begin
            state_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (bit_end && last_data) begin
            state_q <= par_on_q ? ST_PARITY : ST_STOP;
          end
        end
        ST_PARITY: begin
          if (bit_end) begin
            state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (vote_end) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // data and parity capture
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bitcnt_q  <= 4'h0;
      shift_q   <= 9'h000;
      par_bit_q <= 1'b0;
    end else if (start_edge) begin
      bitcnt_q  <= 4'h0;
      shift_q   <= 9'h000;
    end else if (vote_end && state_q == ST_DATA) begin
      bitcnt_q  <= bitcnt_q + 4'h1;
      shift_q   <= {maj_w, shift_q[8:1]};
    end else if (vote_end && state_q == ST_PARITY) begin
      par_bit_q <= maj_w;
    end
  end

  // ==========================================================================
  // completed frame
  // ==========================================================================
  wire logic [3:0] pad_w     = LEN_NINE - len_w;
  wire logic [8:0] aligned_w = shift_q >> pad_w;
  wire logic       perr_w    = par_on_q & (^aligned_w ^ par_odd_q ^ par_bit_q);
  wire logic [ENT_W-1:0] new_ent = {aligned_w, ~maj_w, 1'b0, perr_w};

  // ==========================================================================
  // receive buffer and waiting shift register
  // ==========================================================================
  logic [ENT_W-1:0] buf_q [2];   // two-entry buffer
  logic             wr_ptr_q;
  logic             rd_ptr_q;
  logic [1:0]       count_q;
  logic [ENT_W-1:0] pend_ent_q;  // complete frame waiting for room
  logic             pend_q;
  logic             lost_q;      // a frame was lost since the last transfer

  wire logic done_w    = (count_q != 2'h0);
  wire logic pop_w     = access_w & ~pwrite_i & hit_data & done_w;
  wire logic full_w    = (count_q == BUF_DEPTH);
  wire logic space_w   = ~full_w | pop_w;
  wire logic push_pend = pend_q & space_w;
  wire logic push_new  = frame_done & space_w & ~pend_q;
  wire logic push_w    = push_pend | push_new;
  wire logic hold_new  = frame_done & ~push_new;
  wire logic lost_set  = start_edge & pend_q & full_w;
  logic [ENT_W-1:0] push_ent;

  // attach the overrun mark to the entry being written
  always_comb begin
    push_ent          = push_pend ? pend_ent_q : new_ent;
    push_ent[ENT_DOR] = lost_q;
  end

  // buffer storage
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else if (push_w) begin
      buf_q[wr_ptr_q] <= push_ent;
    end
  end

  // pointers and fill level; receiver off empties the buffer
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end else if (!rx_on_q) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      wr_ptr_q <= wr_ptr_q ^ push_w;
      rd_ptr_q <= rd_ptr_q ^ pop_w;
      count_q  <= count_q + {1'b0, push_w} - {1'b0, pop_w};
    end
  end

  // waiting frame: a newer frame overwrites it while no room is free
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_q     <= 1'b0;
      pend_ent_q <= '0;
    end else if (!rx_on_q) begin
      pend_q     <= 1'b0;
    end else if (hold_new) begin
      pend_q     <= 1'b1;
      pend_ent_q <= new_ent;
    end else if (push_pend) begin
      pend_q     <= 1'b0;
    end
  end

  // overrun mark: a new start beats a transfer in the same cycle
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lost_q <= 1'b0;
    end else if (!rx_on_q) begin
      lost_q <= 1'b0;
    end else if (lost_set) begin
      lost_q <= 1'b1;
    end else if (push_w) begin
      lost_q <= 1'b0;
    end
  end

  // ==========================================================================
  // software control writes
  // ==========================================================================
  // error flag positions are not writable
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dbl_q     <= RST_A[A_DBL];
      irq_on_q  <= RST_B[B_IRQ];
      rx_on_q   <= RST_B[B_ON];
      size2_q   <= RST_B[B_SIZE2];
      par_on_q  <= RST_C[C_PAR_ON];
      par_odd_q <= RST_C[C_PAR_ODD];
      stop2_q   <= RST_C[C_STOP];
      size_lo_q <= {RST_C[C_SIZE_HI], RST_C[C_SIZE_LO]};
    end else begin
      if (wr_a) begin
        dbl_q <= pwdata_i[A_DBL];
      end
      if (wr_b) begin
        irq_on_q <= pwdata_i[B_IRQ];
        rx_on_q  <= pwdata_i[B_ON];
        size2_q  <= pwdata_i[B_SIZE2];
      end
      if (wr_c) begin
        par_on_q  <= pwdata_i[C_PAR_ON];
        par_odd_q <= pwdata_i[C_PAR_ODD];
        stop2_q   <= pwdata_i[C_STOP];
        size_lo_q <= {pwdata_i[C_SIZE_HI], pwdata_i[C_SIZE_LO]};
      end
    end
  end

  // ==========================================================================
  // read side
  // ==========================================================================
  wire logic [ENT_W-1:0] head_w = done_w ? buf_q[rd_ptr_q] : '0;
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic [7:0] rd_c;
  logic [7:0] rd_sel;
  logic [31:0] prdata_q;

  // status and control images
  always_comb begin
    rd_a             = 8'h00;
    rd_a[A_DONE]     = done_w;
    rd_a[A_FE]       = head_w[ENT_FE];
    rd_a[A_DOR]      = head_w[ENT_DOR];
    rd_a[A_PE]       = head_w[ENT_PE] & par_on_q;
    rd_a[A_DBL]      = dbl_q;
    rd_b             = 8'h00;
    rd_b[B_IRQ]      = irq_on_q;
    rd_b[B_ON]       = rx_on_q;
    rd_b[B_SIZE2]    = size2_q;
    rd_b[B_NINTH]    = head_w[ENT_W-1];
    rd_c             = 8'h00;
    rd_c[C_PAR_ON]   = par_on_q;
    rd_c[C_PAR_ODD]  = par_odd_q;
    rd_c[C_STOP]     = stop2_q;
    rd_c[C_SIZE_HI]  = size_lo_q[1];
    rd_c[C_SIZE_LO]  = size_lo_q[0];
  end

  assign rd_sel = hit_data ? head_w[ENT_DATA +: 8] :
                  hit_a    ? rd_a :
                  hit_b    ? rd_b :
                  hit_c    ? rd_c : 8'h00;

  // read data is taken in the setup cycle so it stands during access
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_w) begin
      prdata_q <= {24'h00_0000, rd_sel};
    end
  end

  assign prdata_o       = prdata_q;
  assign irq_o          = done_w & irq_on_q & global_irq_on_i;
  assign pin_override_o = rx_on_q;

endmodule

`default_nettype wire

// ==== hdl/ursrx_pkg.sv ====
/*
  constants, register map, field positions and state encoding of the
  asynchronous serial receiver.
  assumes: one system clock; the sample tick comes from an outside rate generator.
*/
package ursrx_pkg;

  // ==========================================================================
  // register map (byte addresses on the APB)
  // ==========================================================================
  localparam int unsigned ADDR_W       = 12;
  localparam logic [11:0] OFF_DATA     = 12'h000;  // data_buffer_register
  localparam logic [11:0] OFF_STAT_A   = 12'h004;  // status_control_first
  localparam logic [11:0] OFF_CTRL_B   = 12'h008;  // status_control_second
  localparam logic [11:0] OFF_CTRL_C   = 12'h00C;  // status_control_third

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int unsigned A_DONE       = 7;  // receive_done_flag
  localparam int unsigned A_FE         = 4;  // framing_fault_flag
  localparam int unsigned A_DOR        = 3;  // data_lost_flag
  localparam int unsigned A_PE         = 2;  // parity_fault_flag
  localparam int unsigned A_DBL        = 1;  // double_speed_select
  localparam int unsigned B_IRQ        = 7;  // receive_done_irq_on
  localparam int unsigned B_ON         = 4;  // receiver_on
  localparam int unsigned B_SIZE2      = 2;  // character size, high bit
  localparam int unsigned B_NINTH      = 1;  // received_ninth_bit
  localparam int unsigned C_PAR_ON     = 5;  // parity_check_on
  localparam int unsigned C_PAR_ODD    = 4;  // parity_odd_select
  localparam int unsigned C_STOP       = 3;  // stop_bit_count_select
  localparam int unsigned C_SIZE_HI    = 2;  // character size, bit 1
  localparam int unsigned C_SIZE_LO    = 1;  // character size, bit 0

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0]  RST_A        = 8'h00;
  localparam logic [7:0]  RST_B        = 8'h00;
  localparam logic [7:0]  RST_C        = 8'h06;  // eight data bits

  // ==========================================================================
  // sample timing
  // ==========================================================================
  localparam logic [4:0]  SPB_NORMAL   = 5'h10;  // samples per bit, normal
  localparam logic [4:0]  SPB_DOUBLE   = 5'h08;  // samples per bit, double speed
  localparam logic [4:0]  VOTE_NORMAL  = 5'h08;  // first centre sample, normal
  localparam logic [4:0]  VOTE_DOUBLE  = 5'h04;  // first centre sample, double
  localparam logic [4:0]  VOTE_SPAN    = 5'h02;  // last minus first centre sample
  localparam logic [4:0]  CNT_ONE      = 5'h01;
  localparam logic [4:0]  CNT_TWO      = 5'h02;

  // ==========================================================================
  // character size and buffer entry layout
  // ==========================================================================
  localparam logic [2:0]  SIZE_NINE    = 3'h7;
  localparam logic [3:0]  LEN_BASE     = 4'h5;
  localparam logic [3:0]  LEN_EIGHT    = 4'h8;
  localparam logic [3:0]  LEN_NINE     = 4'h9;
  localparam int unsigned DATA_W       = 9;
  localparam int unsigned ENT_W        = 12;
  localparam int unsigned ENT_PE       = 0;
  localparam int unsigned ENT_DOR      = 1;
  localparam int unsigned ENT_FE       = 2;
  localparam int unsigned ENT_DATA     = 3;
  localparam logic [1:0]  BUF_DEPTH    = 2'h2;

  // receiver sequence
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DATA   = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP   = 3'b100
  } ursrx_state_t;

endpackage

// ==== bench/ursrx_top_asserts.sv ====
/* port checker for the serial receiver top
   assumes: bound to ursrx_top, one clock, async low reset */
`timescale 1ns/1ps
`default_nettype none
module ursrx_top_asserts (
  input wire logic                        core_clk_i,
  input wire logic                        arst_n_i,
  input wire logic                        psel_i,
  input wire logic                        penable_i,
  input wire logic                        pwrite_i,
  input wire logic [ursrx_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0]                 pwdata_i,
  input wire logic [3:0]                  pstrb_i,
  input wire logic [31:0]                 prdata_o,
  input wire logic                        pslverr_o,
  input wire logic                        sample_tick_i,
  input wire logic                        global_irq_on_i,
  input wire logic                        irq_o,
  input wire logic                        pin_override_o
);
  import ursrx_pkg::*;
  // ==========================================
  // access decode
  wire acc   = psel_i && penable_i;
  wire wr_b  = acc && pwrite_i && pstrb_i[0] && paddr_i == OFF_CTRL_B;
  wire rd_a  = acc && !pwrite_i && paddr_i == OFF_STAT_A;
  wire rd_d  = acc && !pwrite_i && paddr_i == OFF_DATA;
  wire unmap = acc && !pwrite_i && paddr_i[11:4] != 8'h00;
  wire on_bit = pwdata_i[B_ON];
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_off2; !pin_override_o [*2]; endsequence
  // ==========================================
  // properties
  irq_gate_a: assert property (irq_o |-> global_irq_on_i) else $error("irq without global enable");
  flush_off_a: assert property (s_off2 |-> !irq_o) else $error("irq while receiver off");
  pin_take_a: assert property (wr_b |=> pin_override_o == $past(on_bit)) else $error("pin takeover wrong");
  pin_hold_a: assert property (!wr_b |=> $stable(pin_override_o)) else $error("pin moved alone");
  done_read_a: assert property (rd_a && $past(irq_o) |-> prdata_o[A_DONE]) else $error("done bit low");
  frame_tick_a: assert property ($rose(irq_o) && $stable(global_irq_on_i) && !$past(wr_b)
    && !$past(rd_d) && !$past(rd_d, 2) |-> $past(sample_tick_i)) else $error("done off tick");
  done_fall_a: assert property ($fell(irq_o) && $stable(global_irq_on_i) && !$past(wr_b)
    && pin_override_o && $past(pin_override_o) |-> $past(rd_d)) else $error("done fell alone");
  unmap_err_a: assert property (unmap |-> pslverr_o && prdata_o == 32'h0000_0000) else $error("unmapped ok");
endmodule
bind ursrx_top ursrx_top_asserts u_chk (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .prdata_o(prdata_o), .pslverr_o(pslverr_o), .sample_tick_i(sample_tick_i),
  .global_irq_on_i(global_irq_on_i), .irq_o(irq_o), .pin_override_o(pin_override_o));
`default_nettype wire

// ==== bench/ursrx_tx_model.sv ====
/* remote serial transmitter model, idle high
   assumes: a bit lasts 16 sample ticks, or 8 in double speed */
`timescale 1ns/1ps
`default_nettype none
module ursrx_tx_model (
  input  wire logic core_clk_i,
  input  wire logic sample_tick_i,
  output logic      line_o
);
  initial line_o = 1'b1;
  // hold a level for n sample ticks
  task automatic hold(input logic lvl, input int n);
    line_o <= lvl;
    repeat (n) @(posedge core_clk_i iff sample_tick_i);
  endtask
  // lsb first frame, then one idle bit
  task automatic frame(input logic [11:0] bits, input int n, input int s = 16);
    for (int i = 0; i < n; i++) hold(bits[i], s);
    hold(1'b1, s);
  endtask
endmodule
`default_nettype wire

// ==== bench/ursrx_top_tb.sv ====
/* self-checking bench for the serial receiver
   assumes: design in hdl/, transmitter model drives the line */
`timescale 1ns/1ps
`default_nettype none
module ursrx_top_tb;
  import ursrx_pkg::*;
  logic        core_clk_i      = 1'b0;
  logic        arst_n_i        = 1'b0;
  logic        psel_i          = 1'b0;
  logic        penable_i       = 1'b0;
  logic        pwrite_i        = 1'b0;
  logic [11:0] paddr_i         = 12'h000;
  logic [31:0] pwdata_i        = 32'h0000_0000;
  logic [3:0]  pstrb_i         = 4'hF;
  logic        sample_tick_i   = 1'b0;
  logic        global_irq_on_i = 1'b0;
  logic [31:0] prdata_o, rd_q;
  logic        pready_o, pslverr_o, irq_o, pin_override_o;
  wire         serial_in_i;
  int          n_mismatch      = 0;
  int          checks          = 0;
  always #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) sample_tick_i <= ~sample_tick_i;
  ursrx_top u_dut (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .serial_in_i(serial_in_i),
    .sample_tick_i(sample_tick_i), .global_irq_on_i(global_irq_on_i), .irq_o(irq_o),
    .pin_override_o(pin_override_o));
  ursrx_tx_model u_tx (.core_clk_i(core_clk_i), .sample_tick_i(sample_tick_i), .line_o(serial_in_i));
  // ==========================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 64);
    rd_q = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (k == 64) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e); apb(1'b0, a, 32'h0); check(rd_q, e); endtask
  // ==========================================
  // scenarios
  task automatic t_regs();
    rd(OFF_STAT_A, 32'h0000_0000);
    rd(OFF_CTRL_B, 32'h0000_0000);
    rd(OFF_CTRL_C, 32'h0000_0006);
    rd(12'h010, 32'h0000_0000);
    wr(OFF_STAT_A, 32'h0000_001E);
    rd(OFF_STAT_A, 32'h0000_0002);
    wr(OFF_STAT_A, 32'h0000_0000);
    $display("test regs done");
  endtask
  // four frames, second with bad stop, third lost by overrun
  task automatic t_stream();
    wr(OFF_CTRL_B, 32'h0000_0090);
    global_irq_on_i <= 1'b1;
    u_tx.frame({2'b01, 8'h35, 1'b0}, 10);
    u_tx.frame({2'b00, 8'hCA, 1'b0}, 10);
    u_tx.frame({2'b01, 8'h0F, 1'b0}, 10);
    u_tx.frame({2'b01, 8'hE1, 1'b0}, 10);
    check({31'h0, irq_o}, 32'h1);
    rd(OFF_STAT_A, 32'h0000_0080);
    rd(OFF_DATA, 32'h0000_0035);
    rd(OFF_STAT_A, 32'h0000_0090);
    rd(OFF_DATA, 32'h0000_00CA);
    rd(OFF_STAT_A, 32'h0000_0088);
    rd(OFF_DATA, 32'h0000_00E1);
    rd(OFF_STAT_A, 32'h0000_0000);
    check({31'h0, irq_o}, 32'h0);
    $display("test stream done");
  endtask
  task automatic t_parity();
    wr(OFF_CTRL_C, 32'h0000_0026);
    u_tx.frame({3'b010, 8'h07, 1'b0}, 11);
    rd(OFF_STAT_A, 32'h0000_0084);
    wr(OFF_CTRL_C, 32'h0000_0006);
    rd(OFF_STAT_A, 32'h0000_0080);
    rd(OFF_DATA, 32'h0000_0007);
    wr(OFF_CTRL_C, 32'h0000_0036);
    u_tx.frame({3'b010, 8'h07, 1'b0}, 11);
    rd(OFF_STAT_A, 32'h0000_0080);
    rd(OFF_DATA, 32'h0000_0007);
    wr(OFF_CTRL_C, 32'h0000_0000);
    u_tx.frame({6'h01, 5'h1B, 1'b0}, 7);
    rd(OFF_DATA, 32'h0000_001B);
    $display("test parity done");
  endtask
  // double speed eight-bit frame, then a nine-bit character
  task automatic t_modes();
    wr(OFF_CTRL_C, 32'h0000_0006);
    wr(OFF_STAT_A, 32'h0000_0002);
    u_tx.frame({2'b01, 8'h5C, 1'b0}, 10, 8);
    rd(OFF_DATA, 32'h0000_005C);
    wr(OFF_STAT_A, 32'h0000_0000);
    wr(OFF_CTRL_B, 32'h0000_0094);
    u_tx.frame({2'b01, 9'h1A5, 1'b0}, 11);
    rd(OFF_CTRL_B, 32'h0000_0096);
    rd(OFF_DATA, 32'h0000_00A5);
    wr(OFF_CTRL_B, 32'h0000_0090);
    $display("test modes done");
  endtask
  // glitches at the vote boundary, then switch off mid frame
  task automatic t_noise();
    wr(OFF_CTRL_C, 32'h0000_0006);
    u_tx.hold(1'b0, 7);
    u_tx.hold(1'b1, 200);
    rd(OFF_STAT_A, 32'h0000_0000);
    u_tx.hold(1'b0, 9);
    u_tx.hold(1'b1, 200);
    rd(OFF_STAT_A, 32'h0000_0080);
    u_tx.hold(1'b0, 40);
    wr(OFF_CTRL_B, 32'h0000_0080);
    @(posedge core_clk_i);
    check({31'h0, pin_override_o}, 32'h0);
    rd(OFF_STAT_A, 32'h0000_0000);
    wr(OFF_CTRL_B, 32'h0000_0090);
    u_tx.hold(1'b1, 200);
    rd(OFF_STAT_A, 32'h0000_0000);
    $display("test noise done");
  endtask
  initial begin
    repeat (12) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_stream();
    t_parity();
    t_modes();
    t_noise();
    complete_run();
  end
endmodule
`default_nettype wire
